// ==== core/hsp_pkg.sv ====
package hsp_pkg;

  // Register indexes on the programming link
  localparam logic [3:0] IDX_TEMPERATURE_READING = 4'h0;
  localparam logic [3:0] IDX_RAW_FIELD_VALUE = 4'h1;
  localparam logic [3:0] IDX_FACTORY_COMPENSATED_FIELD = 4'h2;
  localparam logic [3:0] IDX_CUSTOMER_TRIMMED_FIELD = 4'h3;
  localparam logic [3:0] IDX_LINEARIZER_INPUT = 4'h4;
  localparam logic [3:0] IDX_LINEARIZER_OUTPUT = 4'h5;
  localparam logic [3:0] IDX_SCALED_OUTPUT_VALUE = 4'h6;
  localparam logic [3:0] IDX_PRODUCTION_INFO_FIRST = 4'h7;
  localparam logic [3:0] IDX_PRODUCTION_INFO_SECOND = 4'h8;
  localparam logic [3:0] IDX_SELF_TEST_FLAGS = 4'h9;
  localparam logic [3:0] IDX_CUSTOMER_SETUP = 4'hA;
  localparam logic [3:0] IDX_GAIN_COEFF_ZERO = 4'hB;
  localparam logic [3:0] IDX_GAIN_COEFF_ONE = 4'hC;
  localparam logic [3:0] IDX_GAIN_COEFF_TWO = 4'hD;
  localparam logic [3:0] IDX_OFFSET_COEFF_ZERO = 4'hE;
  localparam logic [3:0] IDX_OFFSET_COEFF_ONE = 4'hF;

  // Parameter memory words from the setup word upward
  localparam int NVM_WORDS = 6;

  // Customer setup fields
  localparam int SETUP_LOCK_BIT = 0;
  localparam int SETUP_PWM_LSB = 10;
  localparam int SETUP_PWM_MSB = 11;
  localparam int SETUP_RANGE_LSB = 12;
  localparam int SETUP_RANGE_MSB = 14;
  localparam logic [15:0] SETUP_RESET = 16'h1000;
  localparam logic [15:0] COEFF_RESET = 16'h0000;

  // Self-test flag positions
  localparam int DIAG_FSM_BIT = 5;
  localparam int DIAG_NVM_BIT = 4;
  localparam int DIAG_ROM_BIT = 3;
  localparam int DIAG_OVF_BIT = 2;
  localparam logic [15:0] DIAG_RESET = 16'h0000;

  // PWM rate codes
  localparam logic [1:0] PWM_2KHZ = 2'h3;
  localparam logic [1:0] PWM_1KHZ = 2'h0;
  localparam logic [1:0] PWM_500HZ = 2'h1;
  localparam logic [1:0] PWM_250HZ = 2'h2;
  localparam logic [3:0] PWM_RES_11 = 4'hB;
  localparam logic [3:0] PWM_RES_12 = 4'hC;

  // Link timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS = 10000;
  localparam logic [7:0] BIT_CYC = 8'(BIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] HALF_CYC = 8'(BIT_TIME_NS / CLK_PERIOD_NS / 2);

  // Frame lengths in bits after the start bit, and reply lengths with start bit
  localparam logic [4:0] RX_LEN_READ = 5'h05;
  localparam logic [4:0] RX_LEN_WRITE = 5'h15;
  localparam logic [4:0] TX_LEN_READ = 5'h11;
  localparam logic [4:0] TX_LEN_WRITE = 5'h02;

  typedef enum logic [2:0] {
    HSP_IDLE,
    HSP_START,
    HSP_RX,
    HSP_EXEC,
    HSP_TURN,
    HSP_TX,
    HSP_DONE
  } hsp_state_t;

endpackage

// ==== core/hsp_readout.sv ====
`timescale 1ns/1ps

// Contract
// RULE_01: Lock bit set forbids programming forever; here srst clears the lock again
// RULE_02: Unlocked memory programmed through output pin
// RULE_03: Recognised command executes then replies on pin
// RULE_04: Each device selected through its own pin
// RULE_05: Temperature register is signed 16 bit
// RULE_06: Raw field after range shifter, signed 16
// RULE_07: Raw field rises for south pole
// RULE_08: Measurement taps are read only
// RULE_09: Factory compensated field signed 16 bit
// RULE_10: Customer trimmed field signed 16 bit
// RULE_11: Linearizer input signed 16 bit
// RULE_12: Linearizer output signed 16 bit
// RULE_13: Scaled output signed 16 bit
// RULE_14: Two read-only production info words
// RULE_15: PWM rate field at setup bits 11:10
// RULE_16: PWM code decodes rate and resolution
// RULE_17: Self-test flags, bits 15:6,1:0 reserved
// RULE_18: Bit 5 flags processing FSM failure
// RULE_19: Bit 4 flags power-up memory test failure
// RULE_20: Bit 3 flags program memory parity error
// RULE_21: Bit 2 flags converter overflow
// RULE_22: Raw field saturates at range limits
// RULE_23: Flags sticky; tap writes ignored
module hsp_readout #(
  parameter logic [15:0] PROD_INFO_FIRST = 16'h0000,
  parameter logic [15:0] PROD_INFO_SECOND = 16'h0000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  input wire logic signed [21:0] adc_decimated,
  input wire logic signed [15:0] temperature_in,
  input wire logic signed [15:0] factory_compensated_in,
  input wire logic signed [15:0] customer_trimmed_in,
  input wire logic signed [15:0] linearizer_input_in,
  input wire logic signed [15:0] linearizer_output_in,
  input wire logic signed [15:0] scaled_output_in,
  input wire logic fsm_selftest_fail,
  input wire logic nvm_selftest_done,
  input wire logic nvm_selftest_fail,
  input wire logic rom_parity_error,
  output logic signed [15:0] raw_field_value,
  output logic [15:0] self_test_flags,
  output logic [2:0] range_select,
  output logic [1:0] pwm_rate_select,
  output logic [3:0] pwm_resolution,
  output logic lock_state,
  output logic [15:0] gain_coeff_zero,
  output logic [15:0] gain_coeff_one,
  output logic [15:0] gain_coeff_two,
  output logic [15:0] offset_coeff_zero,
  output logic [15:0] offset_coeff_one
);
  import hsp_pkg::*;

  // Arithmetic shift then clamp to 16 bits; top bit flags the overflow
  function automatic logic [16:0] range_clamp(input logic signed [21:0] v, input logic [2:0] sel);
    logic signed [21:0] s;
    logic [16:0] r;
    s = v >>> (3'h7 - sel);
    r = {1'b0, s[15:0]};
    if (s > 22'sd32767) begin
      r = {1'b1, 16'h7FFF};
    end else if (s < -22'sd32768) begin
      r = {1'b1, 16'h8000};
    end
    return r;
  endfunction

  function automatic logic [3:0] pwm_res_decode(input logic [1:0] code);
    return (code == PWM_2KHZ) ? PWM_RES_11 : PWM_RES_12;
  endfunction

  function automatic logic [2:0] nvm_slot(input logic [3:0] a);
    return 3'(a - IDX_CUSTOMER_SETUP);
  endfunction

  function automatic logic [1:0] pwm_field(input logic [15:0] w);
    return w[SETUP_PWM_MSB:SETUP_PWM_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser

  logic sync1_r, sync2_r, sync3_r, lvl_r, lvl_d_r;
  logic lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    if (sync2_r == sync3_r) begin
      lvl_nxt = sync3_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      lvl_r <= 1'b0;
      lvl_d_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r <= lvl_nxt;
      lvl_d_r <= lvl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Raw field and self-test flags

  logic signed [15:0] raw_r, raw_nxt;
  logic [15:0] diag_r, diag_nxt;
  logic boot_r, boot_nxt;
  logic [16:0] clamp;
  logic [15:0] setup_w;

  always_comb begin
    clamp = range_clamp(adc_decimated, setup_w[SETUP_RANGE_MSB:SETUP_RANGE_LSB]); // RULE_06 RULE_22
    raw_nxt = clamp[15:0]; // RULE_07
    boot_nxt = boot_r & ~nvm_selftest_done;
    diag_nxt = diag_r; // RULE_23
    if (fsm_selftest_fail) begin
      diag_nxt[DIAG_FSM_BIT] = 1'b1; // RULE_18
    end
    if (boot_r && nvm_selftest_done && nvm_selftest_fail) begin
      diag_nxt[DIAG_NVM_BIT] = 1'b1; // RULE_19
    end
    if (rom_parity_error) begin
      diag_nxt[DIAG_ROM_BIT] = 1'b1; // RULE_20
    end
    if (clamp[16]) begin
      diag_nxt[DIAG_OVF_BIT] = 1'b1; // RULE_21
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      raw_r <= 16'sh0000;
      diag_r <= DIAG_RESET; // RULE_17
      boot_r <= 1'b1;
    end else begin
      raw_r <= raw_nxt;
      diag_r <= diag_nxt;
      boot_r <= boot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link frame engine

  hsp_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [4:0] len_r, len_nxt;
  logic [20:0] rx_r, rx_nxt;
  logic [16:0] tx_r, tx_nxt;
  logic wr_r, wr_nxt;
  logic pin_o_nxt, pin_oe_nxt;
  logic nvm_we;
  logic [3:0] addr;
  logic [15:0] rd_data;
  logic lock_w;
  logic [15:0] nvm_r [NVM_WORDS];

  assign addr = wr_r ? rx_r[19:16] : rx_r[3:0];

  // Read mux; taps are sampled at the moment the command executes
  always_comb begin
    unique case (addr)
      IDX_TEMPERATURE_READING: rd_data = temperature_in; // RULE_05
      IDX_RAW_FIELD_VALUE: rd_data = raw_r; // RULE_06
      IDX_FACTORY_COMPENSATED_FIELD: rd_data = factory_compensated_in; // RULE_09
      IDX_CUSTOMER_TRIMMED_FIELD: rd_data = customer_trimmed_in; // RULE_10
      IDX_LINEARIZER_INPUT: rd_data = linearizer_input_in; // RULE_11
      IDX_LINEARIZER_OUTPUT: rd_data = linearizer_output_in; // RULE_12
      IDX_SCALED_OUTPUT_VALUE: rd_data = scaled_output_in; // RULE_13
      IDX_PRODUCTION_INFO_FIRST: rd_data = PROD_INFO_FIRST; // RULE_14
      IDX_PRODUCTION_INFO_SECOND: rd_data = PROD_INFO_SECOND; // RULE_14
      IDX_SELF_TEST_FLAGS: rd_data = diag_r; // RULE_17
      IDX_CUSTOMER_SETUP: rd_data = nvm_r[0];
      IDX_GAIN_COEFF_ZERO: rd_data = nvm_r[1];
      IDX_GAIN_COEFF_ONE: rd_data = nvm_r[2];
      IDX_GAIN_COEFF_TWO: rd_data = nvm_r[3];
      IDX_OFFSET_COEFF_ZERO: rd_data = nvm_r[4];
      IDX_OFFSET_COEFF_ONE: rd_data = nvm_r[5];
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    wr_nxt = wr_r;
    pin_o_nxt = pin_o;
    pin_oe_nxt = pin_oe;
    nvm_we = 1'b0;
    if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
    unique case (state_r)
      HSP_IDLE: begin
        // Only this device's own pin carries its frames
        if (lvl_r && !lvl_d_r) begin // RULE_02 RULE_04
          state_nxt = HSP_START;
          cnt_nxt = HALF_CYC - 8'h01;
        end
      end
      HSP_START: begin
        if (cnt_r == 8'h00) begin
          state_nxt = lvl_r ? HSP_RX : HSP_IDLE;
          cnt_nxt = BIT_CYC - 8'h01;
          idx_nxt = 5'h00;
          len_nxt = RX_LEN_READ;
        end
      end
      HSP_RX: begin
        if (cnt_r == 8'h00) begin
          rx_nxt = {rx_r[19:0], lvl_r};
          idx_nxt = idx_r + 5'h01;
          cnt_nxt = BIT_CYC - 8'h01;
          if (idx_r == 5'h00) begin
            wr_nxt = lvl_r;
            len_nxt = lvl_r ? RX_LEN_WRITE : RX_LEN_READ;
          end
          if (idx_r + 5'h01 == len_nxt) begin
            state_nxt = HSP_EXEC;
          end
        end
      end
      HSP_EXEC: begin
        state_nxt = HSP_TURN;
        cnt_nxt = BIT_CYC - 8'h01;
        idx_nxt = 5'h00;
        if (wr_r) begin
          // Taps and factory words drop writes; a locked part refuses all
          nvm_we = !lock_w && (addr >= IDX_CUSTOMER_SETUP); // RULE_01 RULE_08 RULE_23
          tx_nxt = {1'b1, nvm_we, 15'h0000};
          len_nxt = TX_LEN_WRITE;
        end else begin
          tx_nxt = {1'b1, rd_data};
          len_nxt = TX_LEN_READ;
        end
      end
      HSP_TURN: begin
        if (cnt_r == 8'h00) begin
          state_nxt = HSP_TX; // RULE_03
          cnt_nxt = BIT_CYC - 8'h01;
          pin_oe_nxt = 1'b1;
          pin_o_nxt = tx_r[16];
          tx_nxt = {tx_r[15:0], 1'b0};
        end
      end
      HSP_TX: begin
        if (cnt_r == 8'h00) begin
          idx_nxt = idx_r + 5'h01;
          cnt_nxt = BIT_CYC - 8'h01;
          if (idx_r + 5'h01 == len_r) begin
            state_nxt = HSP_DONE;
            pin_oe_nxt = 1'b0;
            pin_o_nxt = 1'b0;
          end else begin
            pin_o_nxt = tx_r[16];
            tx_nxt = {tx_r[15:0], 1'b0};
          end
        end
      end
      HSP_DONE: begin
        if (cnt_r == 8'h00 && !lvl_r) begin
          state_nxt = HSP_IDLE;
        end
      end
      default: begin
        state_nxt = HSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= HSP_IDLE;
      cnt_r <= 8'h00;
      idx_r <= 5'h00;
      len_r <= RX_LEN_READ;
      rx_r <= 21'h000000;
      tx_r <= 17'h00000;
      wr_r <= 1'b0;
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      wr_r <= wr_nxt;
      pin_o <= pin_o_nxt;
      pin_oe <= pin_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter memory

  // Reset loads SETUP_RESET (16'h1000) and zero coefficients, so srst also clears the lock
  logic [15:0] nvm_nxt [NVM_WORDS];

  assign setup_w = nvm_r[0];
  assign lock_w = nvm_r[0][SETUP_LOCK_BIT];

  always_comb begin
    for (int i = 0; i < NVM_WORDS; i++) begin
      nvm_nxt[i] = nvm_r[i];
    end
    if (nvm_we) begin
      nvm_nxt[nvm_slot(addr)] = rx_r[15:0]; // RULE_02
    end
    // Lock bit cannot be written back to zero
    nvm_nxt[0][SETUP_LOCK_BIT] = nvm_nxt[0][SETUP_LOCK_BIT] | lock_w; // RULE_01
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nvm_r[0] <= SETUP_RESET;
      for (int i = 1; i < NVM_WORDS; i++) begin
        nvm_r[i] <= COEFF_RESET;
      end
    end else begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        nvm_r[i] <= nvm_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk) begin
    if (srst) begin
      range_select <= SETUP_RESET[SETUP_RANGE_MSB:SETUP_RANGE_LSB];
      pwm_rate_select <= pwm_field(SETUP_RESET);
      pwm_resolution <= pwm_res_decode(pwm_field(SETUP_RESET));
      lock_state <= 1'b0;
      gain_coeff_zero <= COEFF_RESET;
      gain_coeff_one <= COEFF_RESET;
      gain_coeff_two <= COEFF_RESET;
      offset_coeff_zero <= COEFF_RESET;
      offset_coeff_one <= COEFF_RESET;
      raw_field_value <= 16'sh0000;
      self_test_flags <= DIAG_RESET;
    end else begin
      range_select <= nvm_nxt[0][SETUP_RANGE_MSB:SETUP_RANGE_LSB];
      pwm_rate_select <= pwm_field(nvm_nxt[0]); // RULE_15
      pwm_resolution <= pwm_res_decode(pwm_field(nvm_nxt[0])); // RULE_16
      lock_state <= nvm_nxt[0][SETUP_LOCK_BIT];
      gain_coeff_zero <= nvm_nxt[1];
      gain_coeff_one <= nvm_nxt[2];
      gain_coeff_two <= nvm_nxt[3];
      offset_coeff_zero <= nvm_nxt[4];
      offset_coeff_one <= nvm_nxt[5];
      raw_field_value <= raw_nxt;
      self_test_flags <= diag_nxt;
    end
  end

endmodule

// ==== sim/hsp_prog_model.sv ====
`timescale 1ns/1ps
module hsp_prog_model
  import hsp_pkg::*;
(
  input wire logic clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_lvl
);
  import hsp_pkg::*;
  logic drv_r = 1'b0;
  // Device wins the shared pin while it replies
  assign pin_lvl = pin_oe ? pin_o : drv_r;
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    logic [21:0] frm;
    int n;
    int k;
    frm = {1'b1, wr, a, d};
    n = wr ? 22 : 6;
    q = 16'h0000;
    ok = 1'b1;
    k = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) drv_r <= frm[21 - i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk) drv_r <= 1'b0;
    while (pin_oe !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (pin_oe !== 1'b1) begin
      ok = 1'b0;
    end else begin
      repeat (HALF_CYC) @(posedge clk);
      if (pin_lvl !== 1'b1) begin
        ok = 1'b0;
      end
      for (int j = 0; j < (wr ? 1 : 16); j++) begin
        repeat (BIT_CYC) @(posedge clk);
        q = {q[14:0], pin_lvl};
      end
      k = 0;
      while (pin_oe !== 1'b0 && k < 300) begin
        @(posedge clk);
        k++;
      end
      repeat (2 * BIT_CYC) @(posedge clk);
    end
  endtask
endmodule

// ==== sim/hsp_readout_monitor.sv ====
`timescale 1ns/1ps
module hsp_readout_monitor
  import hsp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic signed [21:0] adc_decimated,
  input wire logic fsm_selftest_fail,
  input wire logic rom_parity_error,
  input wire logic signed [15:0] raw_field_value,
  input wire logic [15:0] self_test_flags,
  input wire logic [2:0] range_select,
  input wire logic [1:0] pwm_rate_select,
  input wire logic [3:0] pwm_resolution,
  input wire logic lock_state,
  input wire logic [15:0] gain_coeff_zero
);
  import hsp_pkg::*;
  logic signed [21:0] shf;
  logic signed [15:0] sat;
  logic ovf;
  // Expected range-shifted and clamped field
  always_comb begin
    shf = adc_decimated >>> (3'h7 - range_select);
    ovf = (shf > 22'sh007FFF) || (shf < 22'sh3F8000);
    sat = ovf ? (shf[21] ? 16'sh8000 : 16'sh7FFF) : shf[15:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_raw_value;
    1'b1 |=> raw_field_value == $past(sat);
  endproperty
  a_raw_value: assert property (p_raw_value) else $error("raw field mismatch");
  property p_ovf_flag;
    ovf |-> ##[1:2] self_test_flags[DIAG_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");
  property p_fsm_flag;
    fsm_selftest_fail |-> ##[1:2] self_test_flags[DIAG_FSM_BIT];
  endproperty
  a_fsm_flag: assert property (p_fsm_flag) else $error("fsm flag missing");
  property p_rom_flag;
    rom_parity_error |-> ##[1:2] self_test_flags[DIAG_ROM_BIT];
  endproperty
  a_rom_flag: assert property (p_rom_flag) else $error("parity flag missing");
  property p_sticky;
    |self_test_flags |=> (self_test_flags & $past(self_test_flags)) == $past(self_test_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared");
  property p_reserved;
    {self_test_flags[15:6], self_test_flags[1:0]} == 12'h000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved flag set");
  property p_pwm_res;
    pwm_resolution == ((pwm_rate_select == PWM_2KHZ) ? PWM_RES_11 : PWM_RES_12);
  endproperty
  a_pwm_res: assert property (p_pwm_res) else $error("pwm resolution wrong");
  property p_lock_hold;
    lock_state |=> lock_state && $stable(gain_coeff_zero) && $stable(pwm_rate_select) && $stable(range_select);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked memory changed");
  property p_reply_start;
    $rose(pin_oe) |-> pin_o [*8];
  endproperty
  a_reply_start: assert property (p_reply_start) else $error("reply start bit wrong");
  c_reply: cover property ($rose(pin_oe));
  c_lock: cover property ($rose(lock_state));
  c_ovf: cover property (ovf);
endmodule

bind hsp_readout hsp_readout_monitor mon (.clk, .srst, .pin_o, .pin_oe, .adc_decimated, .fsm_selftest_fail,
  .rom_parity_error, .raw_field_value, .self_test_flags, .range_select, .pwm_rate_select, .pwm_resolution,
  .lock_state, .gain_coeff_zero);

// ==== sim/hsp_readout_tb.sv ====
`timescale 1ns/1ps
module hsp_readout_tb;
  import hsp_pkg::*;
  localparam logic [15:0] P1 = 16'h5A3C;
  localparam logic [15:0] P2 = 16'hC3A5;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic signed [21:0] adc = 22'sh000000;
  logic signed [15:0] tap [0:6] = '{default: 16'sh0000};
  logic fsm_fail = 1'b0;
  logic nvm_done = 1'b0;
  logic nvm_fail = 1'b0;
  logic rom_err = 1'b0;
  logic pin_lvl;
  logic pin_o;
  logic pin_oe;
  logic signed [15:0] raw;
  logic [15:0] flags;
  logic [1:0] pwm;
  logic [3:0] res;
  logic lock;
  logic [15:0] gc0;
  logic [2:0] rng;
  logic [15:0] gc1;
  logic [15:0] gc2;
  logic [15:0] oc0;
  logic [15:0] oc1;
  int failures = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  hsp_readout #(.PROD_INFO_FIRST(P1), .PROD_INFO_SECOND(P2)) dut (.clk(clk), .srst(srst), .pin_i(pin_lvl),
    .pin_o(pin_o), .pin_oe(pin_oe), .adc_decimated(adc), .temperature_in(tap[0]),
    .factory_compensated_in(tap[2]), .customer_trimmed_in(tap[3]), .linearizer_input_in(tap[4]),
    .linearizer_output_in(tap[5]), .scaled_output_in(tap[6]), .fsm_selftest_fail(fsm_fail),
    .nvm_selftest_done(nvm_done), .nvm_selftest_fail(nvm_fail), .rom_parity_error(rom_err),
    .raw_field_value(raw), .self_test_flags(flags), .range_select(rng), .pwm_rate_select(pwm),
    .pwm_resolution(res), .lock_state(lock), .gain_coeff_zero(gc0), .gain_coeff_one(gc1), .gain_coeff_two(gc2),
    .offset_coeff_zero(oc0), .offset_coeff_one(oc1));
  hsp_prog_model prg (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    logic ok;
    prg.xfer(wr, a, d, q, ok);
    if (!ok) begin
      failures++;
      $display("ERROR %0t no reply from device", $time);
      test_done();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(16'(pwm), 16'(SETUP_RESET[SETUP_PWM_MSB:SETUP_PWM_LSB]));
    chk(16'(res), 16'(PWM_RES_12));
    chk(16'(lock), 16'h0000);
    chk(flags, DIAG_RESET);
    chk(gc0, COEFF_RESET);
    chk(16'(rng), 16'(SETUP_RESET[SETUP_RANGE_MSB:SETUP_RANGE_LSB]));
  endtask
  task automatic t_taps;
    logic [15:0] q;
    for (int i = 0; i < 7; i++) begin
      tap[i] <= 16'h8001 + 16'(i) * 16'h1234;
    end
    adc <= 22'sh012345;
    for (int a = 0; a < 9; a++) begin
      xf(1'b0, 4'(a), 16'h0000, q);
      // Reset range 1 keeps adc bits 21:6
      chk(q, a == 1 ? 16'(adc >>> 6) : a == 7 ? P1 : a == 8 ? P2 : tap[a]);
    end
  endtask
  task automatic t_tap_write;
    logic [15:0] q;
    xf(1'b1, IDX_TEMPERATURE_READING, 16'h7777, q);
    chk(q, 16'h0000);
    xf(1'b0, IDX_TEMPERATURE_READING, 16'h0000, q);
    chk(q, tap[0]);
  endtask
  task automatic t_pwm;
    logic [15:0] q;
    for (int c = 0; c < 4; c++) begin
      xf(1'b1, IDX_CUSTOMER_SETUP, {4'h1, 2'(c), 10'h000}, q);
      chk(q, 16'h0001);
      chk(16'(pwm), 16'(c));
      chk(16'(res), c == 3 ? 16'(PWM_RES_11) : 16'(PWM_RES_12));
    end
  endtask
  task automatic t_sat;
    logic [15:0] q;
    xf(1'b1, IDX_CUSTOMER_SETUP, 16'h2000, q);
    chk(q, 16'h0001);
    chk(16'(rng), 16'h0002);
    @(posedge clk) adc <= 22'sh100000;
    settle(3);
    chk(raw, 16'h7FFF);
    chk(flags, 16'h0004);
    @(posedge clk) adc <= 22'sh2FFFFF;
    settle(3);
    chk(raw, 16'h8000);
    @(posedge clk) adc <= 22'sh000040;
    settle(3);
    chk(raw, 16'h0002);
    chk(flags, 16'h0004);
  endtask
  task automatic t_flags;
    logic [15:0] q;
    @(posedge clk) fsm_fail <= 1'b1;
    @(posedge clk) fsm_fail <= 1'b0;
    settle(3);
    chk(flags, 16'h0024);
    @(posedge clk) rom_err <= 1'b1;
    @(posedge clk) rom_err <= 1'b0;
    settle(3);
    chk(flags, 16'h002C);
    @(posedge clk) nvm_fail <= 1'b1;
    nvm_done <= 1'b1;
    @(posedge clk) nvm_done <= 1'b0;
    settle(3);
    chk(flags, 16'h003C);
    xf(1'b0, IDX_SELF_TEST_FLAGS, 16'h0000, q);
    chk(q, 16'h003C);
  endtask
  task automatic t_coeffs;
    logic [15:0] q;
    xf(1'b1, IDX_GAIN_COEFF_ONE, 16'h1357, q);
    chk(q, 16'h0001);
    chk(gc1, 16'h1357);
    xf(1'b1, IDX_GAIN_COEFF_TWO, 16'h2468, q);
    chk(gc2, 16'h2468);
    xf(1'b1, IDX_OFFSET_COEFF_ZERO, 16'hA5C3, q);
    chk(oc0, 16'hA5C3);
    xf(1'b1, IDX_OFFSET_COEFF_ONE, 16'h0F0F, q);
    chk(oc1, 16'h0F0F);
    chk(gc0, COEFF_RESET);
  endtask
  task automatic t_lock;
    logic [15:0] q;
    xf(1'b1, IDX_GAIN_COEFF_ZERO, 16'h9C35, q);
    chk(q, 16'h0001);
    chk(gc0, 16'h9C35);
    xf(1'b1, IDX_CUSTOMER_SETUP, 16'h2001, q);
    chk(16'(lock), 16'h0001);
    xf(1'b1, IDX_GAIN_COEFF_ZERO, 16'h1234, q);
    chk(q, 16'h0000);
    xf(1'b1, IDX_CUSTOMER_SETUP, 16'h1C00, q);
    chk(q, 16'h0000);
    chk(16'(lock), 16'h0001);
    xf(1'b0, IDX_GAIN_COEFF_ZERO, 16'h0000, q);
    chk(q, 16'h9C35);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(20);
    srst <= 1'b0;
    settle(5);
    t_reset();
    t_taps();
    t_tap_write();
    t_pwm();
    t_sat();
    t_flags();
    t_coeffs();
    t_lock();
    test_done();
  end
endmodule
